// File: hw/nvc_ctrl.sv
// Data storage access controller with indirect control register and page buffer
`timescale 1ns/1ps
module nvc_ctrl
    import nvc_pkg::*;
#(
    parameter int READ_CYC = nvc_pkg::NVC_READ_CYC,
    parameter int WIPE_CYC = nvc_pkg::NVC_WIPE_CYC,
    parameter int PROG_CYC = nvc_pkg::NVC_PROG_CYC
)
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic clk_en,
    input wire nvc_pkg::nvc_cpu_req_t cpu_req,
    input wire logic [7:0] pointer_high_byte,
    input wire logic [7:0] pointer_low_byte,
    input wire logic low_power_req,
    input wire logic done_flag_clr,
    output logic [7:0] port_rdata,
    output logic [7:0] nvm_data_out,
    output logic [NVC_ADDR_W-1:0] nvm_addr_out,
    output logic nvm_done_flag,
    output logic nvm_busy,
    output logic nvm_fail
);
    import nvc_pkg::*;

    localparam int DEPTH = 1 << NVC_ADDR_W;

    logic [7:0] mem [DEPTH];
    logic [7:0] page_buf [NVC_PAGE_BYTES];
    logic [7:0] ctrl_reg, ctrl_next;
    logic [NVC_ADDR_W-1:0] nvm_addr_reg, nvm_addr_next;
    logic [NVC_ADDR_W-1:0] op_addr_reg, op_addr_next;
    logic [7:0] nvm_data_reg, nvm_data_next;
    logic [NVC_PAGE_BYTES-1:0] buf_valid_reg, buf_valid_next;
    logic [15:0] cnt_reg, cnt_next;
    nvc_state_t state_reg, state_next;
    logic done_reg, done_next;
    logic fail_reg, fail_next;
    logic unused_port;
    logic [7:0] port_q_reg, port_q_next;
    logic sel_ctrl, finish, buf_load;
    logic [3:0] buf_idx;

    // Decode of the indirect port, shared by read and write paths
    function automatic logic ctrl_hit(input logic [7:0] hi, input logic [7:0] lo);
        ctrl_hit = (hi == NVC_CTRL_SECTOR) && (lo == NVC_CTRL_OFFSET);
    endfunction

    assign sel_ctrl = ctrl_hit(pointer_high_byte, pointer_low_byte);
    assign finish = (state_reg != NVC_IDLE) && (cnt_reg == 16'h0001);
    // loads are buffered only while idle, not during a wipe
    // a filled last slot drops further page loads to that slot, buffer included
    assign buf_load = cpu_req.data_wr && (state_reg == NVC_IDLE)
        && !(ctrl_reg[NVC_BIT_PAGE_MODE] && buf_valid_reg[NVC_PAGE_LAST]
        && buf_idx == NVC_PAGE_LAST);
    assign buf_idx = nvm_addr_reg[3:0];
    assign unused_port = cpu_req.port_rd;

    // Control, address, data and sequencing next values
    always_comb
    begin
        ctrl_next = ctrl_reg;
        nvm_addr_next = nvm_addr_reg;
        op_addr_next = op_addr_reg;
        nvm_data_next = nvm_data_reg;
        buf_valid_next = buf_valid_reg;
        cnt_next = cnt_reg;
        state_next = state_reg;
        done_next = done_reg;
        fail_next = fail_reg;
        port_q_next = sel_ctrl ? ctrl_reg : 8'h00;
        if (cpu_req.addr_wr && state_reg == NVC_IDLE)
        begin
            nvm_addr_next = cpu_req.wdata[NVC_ADDR_W-1:0];
        end
        // page loads advance the low nibble, stop at last
        if (buf_load)
        begin
            nvm_data_next = cpu_req.wdata;
            buf_valid_next[buf_idx] = 1'b1;
            if (ctrl_reg[NVC_BIT_PAGE_MODE] && buf_idx != NVC_PAGE_LAST)
            begin
                nvm_addr_next = {nvm_addr_reg[NVC_ADDR_W-1:4], buf_idx + 4'h1};
            end
        end
        if (cpu_req.port_wr && sel_ctrl && state_reg == NVC_IDLE)
        begin
            ctrl_next = cpu_req.wdata & 8'h7f;
            ctrl_next[NVC_BIT_FETCH_START] = cpu_req.wdata[NVC_BIT_FETCH_START]
                && cpu_req.wdata[NVC_BIT_FETCH_ALLOW];
            // start ignored without program-allow already set
            ctrl_next[NVC_BIT_PROG_START] = cpu_req.wdata[NVC_BIT_PROG_START]
                && ctrl_reg[NVC_BIT_PROG_ALLOW];
            ctrl_next[NVC_BIT_WIPE_START] = cpu_req.wdata[NVC_BIT_WIPE_START]
                && ctrl_reg[NVC_BIT_WIPE_ALLOW];
            if (ctrl_next[NVC_BIT_WIPE_START])
            begin
                state_next = NVC_WIPE;
                cnt_next = 16'(WIPE_CYC);
            end
            else if (ctrl_next[NVC_BIT_PROG_START])
            begin
                state_next = NVC_PROG;
                cnt_next = 16'(PROG_CYC);
            end
            else if (ctrl_next[NVC_BIT_FETCH_START])
            begin
                state_next = NVC_READ;
                cnt_next = 16'(READ_CYC);
            end
            op_addr_next = nvm_addr_reg;
            fail_next = 1'b0;
        end
        if (state_reg != NVC_IDLE)
        begin
            cnt_next = cnt_reg - 16'h0001;
        end
        // low-power entry aborts the running operation
        if (state_reg != NVC_IDLE && low_power_req)
        begin
            state_next = NVC_IDLE;
            fail_next = 1'b1;
            ctrl_next[NVC_BIT_FETCH_START] = 1'b0;
            ctrl_next[NVC_BIT_PROG_START] = 1'b0;
            ctrl_next[NVC_BIT_WIPE_START] = 1'b0;
        end
        else if (finish)
        begin
            state_next = NVC_IDLE;
            case (state_reg)
                NVC_READ:
                begin
                    ctrl_next[NVC_BIT_FETCH_START] = 1'b0;
                    nvm_data_next = mem[op_addr_reg];
                end
                NVC_WIPE:
                begin
                    ctrl_next[NVC_BIT_WIPE_START] = 1'b0;
                    ctrl_next[NVC_BIT_WIPE_ALLOW] = 1'b0;
                    done_next = 1'b1;
                end
                NVC_PROG:
                begin
                    ctrl_next[NVC_BIT_PROG_START] = 1'b0;
                    ctrl_next[NVC_BIT_PROG_ALLOW] = 1'b0;
                    done_next = 1'b1;
                end
                default:
                begin
                end
            endcase
        end
        if (done_flag_clr && !(finish && state_reg != NVC_READ && !low_power_req))
        begin
            done_next = 1'b0;
        end
        if (ctrl_reg[NVC_BIT_PROG_ALLOW] && !ctrl_next[NVC_BIT_PROG_ALLOW])
        begin
            buf_valid_next = '0;
        end
    end

    // State registers
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            ctrl_reg <= NVC_CTRL_RESET;
            nvm_addr_reg <= '0;
            op_addr_reg <= '0;
            nvm_data_reg <= 8'h00;
            buf_valid_reg <= '0;
            cnt_reg <= 16'h0000;
            state_reg <= NVC_IDLE;
            done_reg <= 1'b0;
            fail_reg <= 1'b0;
            port_q_reg <= 8'h00;
        end
        else if (clk_en)
        begin
            ctrl_reg <= ctrl_next;
            nvm_addr_reg <= nvm_addr_next;
            op_addr_reg <= op_addr_next;
            nvm_data_reg <= nvm_data_next;
            buf_valid_reg <= buf_valid_next;
            cnt_reg <= cnt_next;
            state_reg <= state_next;
            done_reg <= done_next;
            fail_reg <= fail_next;
            port_q_reg <= port_q_next;
        end
    end

    // Page buffer capture; contents are never cleared, only the valid mask is dropped
    always_ff @(posedge sys_clk)
    begin
        if (clk_en && buf_load)
        begin
            page_buf[buf_idx] <= cpu_req.wdata;
        end
    end

    // Storage array update; not reset, as a real array keeps its data
    always_ff @(posedge sys_clk)
    begin
        if (clk_en && finish && !low_power_req && !rst)
        begin
            if (state_reg == NVC_WIPE)
            begin
                for (int i = 0; i < NVC_PAGE_BYTES; i++)
                begin
                    // page bit widens erase to the whole page
                    if (ctrl_reg[NVC_BIT_PAGE_MODE] || 4'(i) == op_addr_reg[3:0])
                    begin
                        mem[{op_addr_reg[NVC_ADDR_W-1:4], 4'(i)}] <= 8'h00;
                    end
                end
            end
            else if (state_reg == NVC_PROG)
            begin
                for (int i = 0; i < NVC_PAGE_BYTES; i++)
                begin
                    // byte write implies prior erase, new byte overwrites
                    if (ctrl_reg[NVC_BIT_PAGE_MODE] ? buf_valid_reg[i]
                        : 4'(i) == op_addr_reg[3:0])
                    begin
                        mem[{op_addr_reg[NVC_ADDR_W-1:4], 4'(i)}] <=
                            ctrl_reg[NVC_BIT_PAGE_MODE] ? page_buf[i] : nvm_data_reg;
                    end
                end
            end
        end
    end

    assign port_rdata = port_q_reg;
    assign nvm_data_out = nvm_data_reg;
    assign nvm_addr_out = nvm_addr_reg;
    assign nvm_done_flag = done_reg;
    assign nvm_busy = (state_reg != NVC_IDLE);
    assign nvm_fail = fail_reg;
endmodule

// File: common/nvc_pkg.sv
// Package for the data storage access controller: offsets, fields, timings, types
package nvc_pkg;
    // Sector and low address of the control register behind the indirect port
    localparam logic [7:0] NVC_CTRL_SECTOR = 8'h01;
    localparam logic [7:0] NVC_CTRL_OFFSET = 8'h40;
    localparam logic [7:0] NVC_CTRL_RESET = 8'h00;
    // Control register bit positions
    localparam int NVC_BIT_FETCH_START = 0;
    localparam int NVC_BIT_FETCH_ALLOW = 1;
    localparam int NVC_BIT_PROG_START = 2;
    localparam int NVC_BIT_PROG_ALLOW = 3;
    localparam int NVC_BIT_PAGE_MODE = 4;
    localparam int NVC_BIT_WIPE_START = 5;
    localparam int NVC_BIT_WIPE_ALLOW = 6;
    // Storage geometry
    localparam int NVC_ADDR_W = 7;
    localparam int NVC_PAGE_BYTES = 16;
    localparam logic [3:0] NVC_PAGE_LAST = 4'hf;
    // Cycle durations in ns, no figures are printed so these are plain defaults
    localparam int NVC_CLK_NS = 25;
    localparam int NVC_READ_NS = 100;
    localparam int NVC_WIPE_NS = 2000;
    localparam int NVC_PROG_NS = 2000;
    localparam int NVC_READ_CYC = (NVC_READ_NS + NVC_CLK_NS - 1) / NVC_CLK_NS;
    localparam int NVC_WIPE_CYC = (NVC_WIPE_NS + NVC_CLK_NS - 1) / NVC_CLK_NS;
    localparam int NVC_PROG_CYC = (NVC_PROG_NS + NVC_CLK_NS - 1) / NVC_CLK_NS;

    typedef enum logic [1:0] {
        NVC_IDLE,
        NVC_READ,
        NVC_WIPE,
        NVC_PROG
    } nvc_state_t;

    // CPU side access to the indirect port and to the address and data registers
    typedef struct packed {
        logic port_wr;
        logic port_rd;
        logic addr_wr;
        logic data_wr;
        logic [7:0] wdata;
    } nvc_cpu_req_t;
endpackage

// File: testbench/nvc_ctrl_monitor.sv
// Port checker for the storage access controller
`timescale 1ns/1ps
module nvc_ctrl_monitor
    import nvc_pkg::*;
#(
    parameter int READ_CYC = 3,
    parameter int WIPE_CYC = 5,
    parameter int PROG_CYC = 4
)
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic clk_en,
    input wire nvc_pkg::nvc_cpu_req_t cpu_req,
    input wire logic [7:0] pointer_high_byte,
    input wire logic [7:0] pointer_low_byte,
    input wire logic low_power_req,
    input wire logic done_flag_clr,
    input wire logic [7:0] port_rdata,
    input wire logic [NVC_ADDR_W-1:0] nvm_addr_out,
    input wire logic nvm_done_flag,
    input wire logic nvm_busy,
    input wire logic nvm_fail
);
    logic [7:0] busy_cnt_reg;
    logic [7:0] busy_cnt_next;
    logic idle_wr;
    // Busy length, frozen with the clock enable so it tracks the design's timer
    always_comb
    begin
        busy_cnt_next = nvm_busy ? busy_cnt_reg + 8'h01 : 8'h00;
    end
    always_ff @(posedge sys_clk)
    begin
        busy_cnt_reg <= rst ? 8'h00 : (clk_en ? busy_cnt_next : busy_cnt_reg);
    end
    assign idle_wr = clk_en && !nvm_busy && cpu_req.port_wr && pointer_low_byte == NVC_CTRL_OFFSET
        && pointer_high_byte == NVC_CTRL_SECTOR;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    property p_gate;
        clk_en && pointer_high_byte != NVC_CTRL_SECTOR |=> port_rdata == 8'h00;
    endproperty
    a_gate: assert property (p_gate) else $error("control visible off sector");
    property p_nosel;
        clk_en && !nvm_busy && cpu_req.port_wr && pointer_high_byte == 8'h00 |=> !nvm_busy;
    endproperty
    a_nosel: assert property (p_nosel) else $error("start from wrong sector");
    property p_fetch_go;
        idle_wr && !low_power_req && cpu_req.wdata == 8'h03 |=> nvm_busy;
    endproperty
    a_fetch_go: assert property (p_fetch_go) else $error("read did not start");
    property p_len;
        $fell(nvm_busy) && !nvm_fail |-> busy_cnt_reg == READ_CYC || busy_cnt_reg == WIPE_CYC
            || busy_cnt_reg == PROG_CYC;
    endproperty
    a_len: assert property (p_len) else $error("cycle length wrong");
    property p_done;
        $fell(nvm_busy) && !nvm_fail && busy_cnt_reg != READ_CYC |-> nvm_done_flag;
    endproperty
    a_done: assert property (p_done) else $error("done flag not set");
    property p_sticky;
        clk_en && nvm_done_flag && !done_flag_clr |=> nvm_done_flag;
    endproperty
    a_sticky: assert property (p_sticky) else $error("done flag lost");
    property p_abort;
        clk_en && nvm_busy && low_power_req |=> !nvm_busy && nvm_fail;
    endproperty
    a_abort: assert property (p_abort) else $error("abort not taken");
    property p_stop;
        clk_en && !nvm_busy && cpu_req.data_wr && !cpu_req.addr_wr
            && nvm_addr_out[3:0] == NVC_PAGE_LAST |=> $stable(nvm_addr_out);
    endproperty
    a_stop: assert property (p_stop) else $error("address rolled past page end");
endmodule
bind nvc_ctrl nvc_ctrl_monitor #(.READ_CYC(READ_CYC), .WIPE_CYC(WIPE_CYC), .PROG_CYC(PROG_CYC))
    u_mon (.sys_clk(sys_clk), .rst(rst), .clk_en(clk_en), .cpu_req(cpu_req),
    .pointer_high_byte(pointer_high_byte), .pointer_low_byte(pointer_low_byte),
    .low_power_req(low_power_req), .done_flag_clr(done_flag_clr), .port_rdata(port_rdata),
    .nvm_addr_out(nvm_addr_out), .nvm_done_flag(nvm_done_flag), .nvm_busy(nvm_busy),
    .nvm_fail(nvm_fail));

// File: testbench/tb_nvc_ctrl.sv
// Self-checking bench for the storage access controller
`timescale 1ns/1ps
module tb_nvc_ctrl;
    import nvc_pkg::*;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic clk_en = 1'b1;
    nvc_cpu_req_t cpu_req = '0;
    logic [7:0] pointer_high_byte = 8'h01;
    logic [7:0] pointer_low_byte = 8'h40;
    logic low_power_req = 1'b0;
    logic done_flag_clr = 1'b0;
    logic [7:0] port_rdata;
    logic [7:0] nvm_data_out;
    logic [NVC_ADDR_W-1:0] nvm_addr_out;
    logic nvm_done_flag;
    logic nvm_busy;
    logic nvm_fail;
    int miscompares = 0;
    int n_tests = 0;
    int cycles = 0;
    nvc_ctrl #(.READ_CYC(3), .WIPE_CYC(5), .PROG_CYC(4)) uut (.sys_clk(sys_clk), .rst(rst),
        .clk_en(clk_en), .cpu_req(cpu_req), .pointer_high_byte(pointer_high_byte),
        .pointer_low_byte(pointer_low_byte), .low_power_req(low_power_req),
        .done_flag_clr(done_flag_clr), .port_rdata(port_rdata), .nvm_data_out(nvm_data_out),
        .nvm_addr_out(nvm_addr_out), .nvm_done_flag(nvm_done_flag), .nvm_busy(nvm_busy),
        .nvm_fail(nvm_fail));
    // 40 MHz clock
    always #12.5 sys_clk = ~sys_clk;
    // Hang guard, far above the few hundred cycles the run needs
    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            miscompares++;
            end_sim();
        end
    end
    task automatic end_sim();
        if (miscompares == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp)
        begin
            miscompares++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    // One request per falling edge; kind 1 port, 2 address, 3 data, 0 none
    task automatic req(input int kind, input logic [7:0] d);
        nvc_cpu_req_t r;
        r = '0;
        r.wdata = d;
        r.port_wr = (kind == 1);
        r.addr_wr = (kind == 2);
        r.data_wr = (kind == 3);
        @(negedge sys_clk);
        cpu_req = r;
    endtask
    // Allow and start on adjacent cycles, then poll the busy flag with a bound
    task automatic op(input logic [7:0] a, input logic [7:0] b);
        req(1, a);
        req(1, b);
        req(0, 8'h00);
        for (int i = 0; i < 40 && nvm_busy === 1'b1; i++)
            @(negedge sys_clk);
        // Port copy of control lags the register by one cycle
        @(negedge sys_clk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] exp);
        req(2, a);
        op(m | 8'h02, m | 8'h03);
        chk("read data", exp, nvm_data_out);
    endtask
    task automatic clr_done();
        @(negedge sys_clk);
        done_flag_clr = 1'b1;
        @(negedge sys_clk);
        done_flag_clr = 1'b0;
        chk("done clear", 8'h00, {7'h00, nvm_done_flag});
    endtask
    // Main sequence: byte, page, erase, protection and abort
    initial
    begin
        repeat (4) @(negedge sys_clk);
        rst = 1'b0;
        req(0, 8'h00);
        chk("ctrl reset", NVC_CTRL_RESET, port_rdata);
        req(2, 8'h25);
        req(3, 8'ha5);
        op(8'h08, 8'h0c);
        chk("wr done", 8'h01, {7'h00, nvm_done_flag});
        chk("ctrl after wr", 8'h00, port_rdata);
        clr_done();
        rd(8'h25, 8'h00, 8'ha5);
        chk("ctrl after rd", 8'h02, port_rdata);
        chk("rd no done", 8'h00, {7'h00, nvm_done_flag});
        req(1, 8'h00);
        req(1, 8'h01);
        req(1, 8'h04);
        req(0, 8'h00);
        chk("lone starts", 8'h00, {7'h00, nvm_busy});
        req(2, 8'h30);
        req(1, 8'h10);
        for (int i = 0; i < 17; i++)
            req(3, 8'h40 + i[7:0]);
        req(0, 8'h00);
        chk("page addr", 8'h3f, {1'b0, nvm_addr_out});
        op(8'h18, 8'h1c);
        chk("pg done", 8'h01, {7'h00, nvm_done_flag});
        chk("ctrl after pg", 8'h10, port_rdata);
        clr_done();
        for (int i = 0; i < 16; i++)
            rd(8'h30 + i[7:0], 8'h10, 8'h40 + i[7:0]);
        req(2, 8'h30);
        req(3, 8'hff);
        op(8'h50, 8'h70);
        chk("erase done", 8'h01, {7'h00, nvm_done_flag});
        chk("ctrl after erase", 8'h10, port_rdata);
        rd(8'h30, 8'h10, 8'h00);
        clr_done();
        pointer_high_byte = 8'h00;
        op(8'h08, 8'h0c);
        chk("blocked busy", 8'h00, {7'h00, nvm_busy});
        chk("blocked read", 8'h00, port_rdata);
        pointer_high_byte = 8'h01;
        req(2, 8'h25);
        req(1, 8'h08);
        req(1, 8'h0c);
        req(0, 8'h00);
        low_power_req = 1'b1;
        @(negedge sys_clk);
        low_power_req = 1'b0;
        chk("abort busy", 8'h00, {7'h00, nvm_busy});
        chk("abort fail", 8'h01, {7'h00, nvm_fail});
        // Abort keeps the allow bit, so software drops it itself
        req(1, 8'h00);
        req(0, 8'h00);
        chk("abort keeps allow", 8'h08, port_rdata);
        req(0, 8'h00);
        chk("allow dropped", 8'h00, port_rdata);
        end_sim();
    end
endmodule
